/* core/dhpw_top.sv */
// Overview of operation
// [R1] Two outputs, each with four modes; stepper mode is not built and drives the output low
// [R2] Normal mode drives the software bit
// [R3] PWM mode drives the channel generator
// [R4] Channels enabled and programmed independently
// [R5] Duty 0..32000 sets high fraction
// [R6] Duty 0 off, 32000 fully on
// [R7] Frequency register holds hertz directly
// [R8] Period equals one over frequency
// [R9] Parameters change live, no restart
// [R10] Output low until both nonzero
// [R11] Stop mode holds or uses stop values
// [R12] Zero stop parameter keeps output low
// [R13] Match mode follows counter comparison
// [R14] High from period start, then low
//
// Local design decisions: the address map and the APB slave port.
`include "dhpw_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module dhpw_top (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  input wire logic [1:0] counter_match_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  output logic fast_output_one_o,
  output logic fast_output_two_o
);

  logic [31:0] ctrl_q;
  logic [31:0] duty_q [2];
  logic [31:0] freq_q [2];
  logic [31:0] stop_duty_q [2];
  logic [31:0] stop_freq_q [2];
  logic [1:0] armed_q;
  logic [1:0] pwm_lvl;
  logic [1:0] out_q;
  logic access;
  logic wr_en;
  logic rd_en;
  logic reload;
  logic stop_mode;
  logic [1:0] hold_last;
  logic [1:0] soft_bit;

  // Offset within the window of channel ch, or all ones when outside it
  function automatic logic [11:0] chan_ofs(input logic [11:0] a, input int ch);
    logic [11:0] base;
    base = 12'(`DHPW_OFS_CH_BASE + ch * `DHPW_OFS_CH_STRIDE);
    if (a >= base && a < 12'(base + `DHPW_OFS_CH_STRIDE)) begin
      chan_ofs = 12'(a - base);
    end else begin
      chan_ofs = 12'hFFF;
    end
  endfunction

  // Mode field of one output
  function automatic logic [1:0] mode_of(input logic [31:0] c, input int ch);
    if (ch == 0) begin
      mode_of = c[`DHPW_CTRL_MODE0_LSB +: 2];
    end else begin
      mode_of = c[`DHPW_CTRL_MODE1_LSB +: 2];
    end
  endfunction

  function automatic logic addr_known(input logic [11:0] a);
    logic hit;
    hit = 1'b0;
    if (a == `DHPW_OFS_CTRL) begin
      hit = 1'b1;
    end else if (a == `DHPW_OFS_STATUS) begin
      hit = 1'b1;
    end else if (chan_ofs(a, 0) != 12'hFFF && a[1:0] == 2'h0) begin
      hit = 1'b1;
    end else if (chan_ofs(a, 1) != 12'hFFF && a[1:0] == 2'h0) begin
      hit = 1'b1;
    end
    addr_known = hit;
  endfunction

  // Byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge = r;
  endfunction

  // Write strobe for one word of a channel window
  function automatic logic param_hit(input logic we, input logic [11:0] a, input int ch,
                                     input logic [11:0] ofs);
    logic hit;
    hit = we && (chan_ofs(a, ch) == ofs);
    param_hit = hit;
  endfunction

  // Every access takes one wait state; the answer is registered
  assign access = psel_i && penable_i && !pready_o;
  assign wr_en = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
  assign rd_en = access && !pwrite_i;

  // One-cycle pulse; a held access is answered again every second cycle
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pready_o <= 1'b0;
    end else begin
      pready_o <= access;
    end
  end

  // Unaligned or unmapped words are refused; status writes are dropped silently
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      pslverr_o <= 1'b0;
    end else if (access) begin
      pslverr_o <= !addr_known(paddr_i);
    end else begin
      pslverr_o <= 1'b0;
    end
  end

  // Loaded by each read and zeroed by each write access; the last word is held while the bus idles
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0;
    end else if (rd_en) begin
      if (paddr_i == `DHPW_OFS_CTRL) begin
        prdata_o <= ctrl_q;
      end else if (paddr_i == `DHPW_OFS_STATUS) begin
        prdata_o <= {28'h0, out_q, armed_q};
      end else if (chan_ofs(paddr_i, 0) == `DHPW_OFS_DUTY) begin
        prdata_o <= duty_q[0];
      end else if (chan_ofs(paddr_i, 0) == `DHPW_OFS_FREQ) begin
        prdata_o <= freq_q[0];
      end else if (chan_ofs(paddr_i, 0) == `DHPW_OFS_STOP_DUTY) begin
        prdata_o <= stop_duty_q[0];
      end else if (chan_ofs(paddr_i, 0) == `DHPW_OFS_STOP_FREQ) begin
        prdata_o <= stop_freq_q[0];
      end else if (chan_ofs(paddr_i, 1) == `DHPW_OFS_DUTY) begin
        prdata_o <= duty_q[1];
      end else if (chan_ofs(paddr_i, 1) == `DHPW_OFS_FREQ) begin
        prdata_o <= freq_q[1];
      end else if (chan_ofs(paddr_i, 1) == `DHPW_OFS_STOP_DUTY) begin
        prdata_o <= stop_duty_q[1];
      end else if (chan_ofs(paddr_i, 1) == `DHPW_OFS_STOP_FREQ) begin
        prdata_o <= stop_freq_q[1];
      end else begin
        prdata_o <= 32'h0;
      end
    end else if (access) begin
      prdata_o <= 32'h0;
    end
  end

  // Control register; the reload bit is a write-one strobe, never stored
  assign reload = wr_en && (paddr_i == `DHPW_OFS_CTRL) && pstrb_i[1] &&
                  pwdata_i[`DHPW_CTRL_RELOAD_BIT];

  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `DHPW_CTRL_RESET;
    end else if (wr_en && paddr_i == `DHPW_OFS_CTRL) begin
      ctrl_q <= merge(ctrl_q, pwdata_i, pstrb_i) & 32'h0000_01FF;
    end
  end

  assign stop_mode = ctrl_q[`DHPW_CTRL_STOP_BIT];
  assign hold_last = {ctrl_q[`DHPW_CTRL_HOLD1_BIT], ctrl_q[`DHPW_CTRL_HOLD0_BIT]};
  assign soft_bit = {ctrl_q[`DHPW_CTRL_SOFT1_BIT], ctrl_q[`DHPW_CTRL_SOFT0_BIT]};

  // [R1] two independent outputs
  for (genvar i = 0; i < 2; i++) begin : g_ch
    logic [1:0] mode;
    logic [31:0] use_freq;
    logic [31:0] use_duty;
    logic run;
    logic hold;

    // Mode may change any cycle; entering PWM restarts from phase 0
    assign mode = mode_of(ctrl_q, i);

    // [R9] live parameter update
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || reload) begin
        duty_q[i] <= `DHPW_PARAM_RESET;
      end else if (param_hit(wr_en, paddr_i, i, `DHPW_OFS_DUTY)) begin
        duty_q[i] <= merge(duty_q[i], pwdata_i, pstrb_i);
      end
    end

    // [R7] frequency in hertz
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || reload) begin
        freq_q[i] <= `DHPW_PARAM_RESET;
      end else if (param_hit(wr_en, paddr_i, i, `DHPW_OFS_FREQ)) begin
        freq_q[i] <= merge(freq_q[i], pwdata_i, pstrb_i);
      end
    end

    // Stop values survive a reload; they are configuration, not program data
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        stop_duty_q[i] <= `DHPW_PARAM_RESET;
      end else if (param_hit(wr_en, paddr_i, i, `DHPW_OFS_STOP_DUTY)) begin
        stop_duty_q[i] <= merge(stop_duty_q[i], pwdata_i, pstrb_i);
      end
    end

    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        stop_freq_q[i] <= `DHPW_PARAM_RESET;
      end else if (param_hit(wr_en, paddr_i, i, `DHPW_OFS_STOP_FREQ)) begin
        stop_freq_q[i] <= merge(stop_freq_q[i], pwdata_i, pstrb_i);
      end
    end

    // [R10] arm on nonzero pair
    // Reload outranks arming: in its own cycle the old
    // values are still nonzero and would re-arm the channel
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i || reload) begin
        armed_q[i] <= 1'b0;
      end else if (duty_q[i] != 32'h0 && freq_q[i] != 32'h0) begin
        armed_q[i] <= 1'b1;
      end
    end

    // Hold freezes phase and level, so leaving stop resumes mid-period
    // [R11] stop: hold or stop values
    always_comb begin
      if (stop_mode && !hold_last[i]) begin
        use_freq = stop_freq_q[i];
        use_duty = stop_duty_q[i];
      end else begin
        use_freq = freq_q[i];
        use_duty = duty_q[i];
      end
      hold = stop_mode && hold_last[i];
    end

    // Stop mode needs no arming: its own zero test stands in for it
    // [R4] per-channel enable
    // [R12] zero stop value low
    assign run = (mode == dhpw_pkg::DHPW_MODE_PWM) &&
                 (stop_mode ? (use_freq != 32'h0 && use_duty != 32'h0) : armed_q[i]);

    // [R5] duty scaled to 32000
    dhpw_chan u_chan (
      .core_clk_i(core_clk_i),
      .sys_rst_i(sys_rst_i),
      .freq_i(use_freq),
      .duty_i(use_duty),
      .run_i(run),
      .hold_i(hold),
      .pwm_o(pwm_lvl[i])
    );

    // Output mux; stepper is not built here and idles low
    always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
        out_q[i] <= 1'b0;
      end else begin
        case (mode)
          // [R2] software bit drives
          dhpw_pkg::DHPW_MODE_NORMAL: begin
            out_q[i] <= soft_bit[i];
          end
          // [R3] generator drives
          dhpw_pkg::DHPW_MODE_PWM: begin
            out_q[i] <= pwm_lvl[i];
          end
          // [R13] counter comparison drives
          dhpw_pkg::DHPW_MODE_MATCH: begin
            out_q[i] <= counter_match_i[i];
          end
          default: begin
            out_q[i] <= 1'b0;
          end
        endcase
      end
    end
  end

  // Pins come straight from out_q, so a mode change never glitches them
  assign fast_output_one_o = out_q[0];
  assign fast_output_two_o = out_q[1];

endmodule

`default_nettype wire

/* core/dhpw_defs.svh */
`ifndef DHPW_DEFS_SVH
`define DHPW_DEFS_SVH

// Core clock
`define DHPW_CLK_PERIOD_NS 4
`define DHPW_CLK_HZ (1000000000 / `DHPW_CLK_PERIOD_NS)

// Duty scale: full on
`define DHPW_DUTY_FULL 32000

// Register byte offsets
`define DHPW_OFS_CTRL 12'h000
`define DHPW_OFS_STATUS 12'h004
`define DHPW_OFS_CH_BASE 12'h010
`define DHPW_OFS_CH_STRIDE 12'h010
`define DHPW_OFS_DUTY 12'h000
`define DHPW_OFS_FREQ 12'h004
`define DHPW_OFS_STOP_DUTY 12'h008
`define DHPW_OFS_STOP_FREQ 12'h00C

// Control fields
`define DHPW_CTRL_MODE0_LSB 0
`define DHPW_CTRL_MODE1_LSB 2
`define DHPW_CTRL_SOFT0_BIT 4
`define DHPW_CTRL_SOFT1_BIT 5
`define DHPW_CTRL_STOP_BIT 6
`define DHPW_CTRL_HOLD0_BIT 7
`define DHPW_CTRL_HOLD1_BIT 8
`define DHPW_CTRL_RELOAD_BIT 9
`define DHPW_CTRL_RESET 32'h0000_0000

// Status fields
`define DHPW_STAT_ARMED_LSB 0
`define DHPW_STAT_OUT_LSB 2

// Parameter register reset value
`define DHPW_PARAM_RESET 32'h0000_0000

`endif

/* core/dhpw_pkg.sv */
package dhpw_pkg;

  typedef enum logic [1:0] {
    DHPW_MODE_NORMAL = 2'h0,
    DHPW_MODE_PWM = 2'h1,
    DHPW_MODE_MATCH = 2'h2,
    DHPW_MODE_STEPPER = 2'h3
  } dhpw_mode_t;

endpackage

/* core/dhpw_chan.sv */
`include "dhpw_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module dhpw_chan (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [31:0] freq_i,
  input wire logic [31:0] duty_i,
  input wire logic run_i,
  input wire logic hold_i,
  output logic pwm_o
);

  localparam logic [31:0] CLK_HZ = 32'(`DHPW_CLK_HZ);
  localparam logic [31:0] DUTY_FULL = 32'(`DHPW_DUTY_FULL);

  logic [31:0] step;
  logic [32:0] sum;
  logic [31:0] phase_q;
  logic [31:0] phase_d;
  logic [31:0] duty_c;
  logic [63:0] lhs;
  logic [63:0] rhs;
  logic level;

  // Phase accumulator: a wrap marks each period start, so the average
  // period is exactly 1/freq below the clock rate; single periods jitter by one clock.
  always_comb begin
    step = (freq_i >= CLK_HZ) ? (CLK_HZ - 32'h1) : freq_i;
    sum = {1'b0, phase_q} + {1'b0, step};
    phase_d = (sum >= {1'b0, CLK_HZ}) ? 32'(sum - {1'b0, CLK_HZ}) : sum[31:0];
    duty_c = (duty_i > DUTY_FULL) ? DUTY_FULL : duty_i;
    lhs = 64'(phase_q) * 64'(DUTY_FULL);
    rhs = 64'(duty_c) * 64'(CLK_HZ);
    // [R14] high then low
    level = (lhs < rhs);
  end

  // [R8] period from frequency
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !run_i) begin
      phase_q <= 32'h0;
    end else if (!hold_i) begin
      phase_q <= phase_d;
    end
  end

  // [R6] zero off, full on
  always_ff @(posedge core_clk_i) begin
    if (sys_rst_i || !run_i) begin
      pwm_o <= 1'b0;
    end else if (!hold_i) begin
      pwm_o <= (freq_i != 32'h0) && level;
    end
  end

endmodule

`default_nettype wire

/* tb/dhpw_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module dhpw_top_props (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic fast_output_one_o,
  input wire logic fast_output_two_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic mapped;
  // Only whole aligned words are mapped
  assign mapped = (paddr_i[1:0] == 2'h0) && (paddr_i inside {12'h000, 12'h004, [12'h010:12'h02C]});
  property p_rdy_gap; pready_o |=> !pready_o [*2]; endproperty
  a_rdy_gap: assert property (p_rdy_gap) else $error("ready too long");
  property p_rdy_lat; psel_i && $rose(penable_i) |=> pready_o; endproperty
  a_rdy_lat: assert property (p_rdy_lat) else $error("ready late");
  property p_rdy_cause; pready_o |-> psel_i && penable_i && $past(penable_i); endproperty
  a_rdy_cause: assert property (p_rdy_cause) else $error("ready early");
  property p_err_zero; pslverr_o |-> pready_o && prdata_o == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("error without ready");
  property p_err_map; pready_o && !mapped |-> pslverr_o; endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped not refused");
  property p_map_ok; pready_o && mapped |-> !pslverr_o; endproperty
  a_map_ok: assert property (p_map_ok) else $error("mapped refused");
  property p_idle; !psel_i |-> !pready_o && !pslverr_o; endproperty
  a_idle: assert property (p_idle) else $error("answer while idle");
  property p_rst_out; $fell(sys_rst_i) |-> (!fast_output_one_o && !fast_output_two_o) [*5]; endproperty
  a_rst_out: assert property (p_rst_out) else $error("output after reset");
endmodule
bind dhpw_top dhpw_top_props i_dhpw_top_props (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .fast_output_one_o(fast_output_one_o), .fast_output_two_o(fast_output_two_o));
`default_nettype wire

/* tb/dhpw_load.sv */
`timescale 1ns/1ps
`default_nettype none
module dhpw_load (
  input wire logic core_clk_i,
  input wire logic pin_i,
  output logic [15:0] high_o,
  output logic [15:0] per_o
);
  // Figures latch at each rising edge, so a steady pin keeps old ones
  logic last_q = 1'b0;
  logic [15:0] hc_q = 16'h0000;
  logic [15:0] pc_q = 16'h0000;
  always_ff @(posedge core_clk_i) begin
    last_q <= pin_i;
    if (pin_i && !last_q) begin
      per_o <= pc_q;
      high_o <= hc_q;
      pc_q <= 16'h0001;
      hc_q <= 16'h0001;
    end else begin
      pc_q <= pc_q + 16'h0001;
      hc_q <= hc_q + {15'h0000, pin_i};
    end
  end
endmodule
`default_nettype wire

/* tb/dual_high_speed_output_pwm_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module dual_high_speed_output_pwm_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h000;
  logic [31:0] pwd = 32'h0000_0000;
  logic [1:0] cm = 2'h0;
  logic [31:0] prd, rd;
  logic rdy, err, re, q1, q2, v;
  logic [15:0] h1, p1, h2, p2;
  int failures = 0;
  int n_tests = 0;
  always #2 clk = ~clk;
  dhpw_top i_dhpw_top (.core_clk_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(pa), .pwdata_i(pwd), .pstrb_i(4'hF), .counter_match_i(cm), .prdata_o(prd), .pready_o(rdy),
    .pslverr_o(err), .fast_output_one_o(q1), .fast_output_two_o(q2));
  dhpw_load i_dhpw_load (.core_clk_i(clk), .pin_i(q1), .high_o(h1), .per_o(p1));
  dhpw_load i_dhpw_load_b (.core_clk_i(clk), .pin_i(q2), .high_o(h2), .per_o(p2));
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %0h, seen %0h", nm, exp, got);
    end
  endtask
  task automatic w8(input int n);
    repeat (n) @(posedge clk);
  endtask
  // An idle cycle follows each transfer; only the watchdog ends a wait
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'b1);
    rd = prd;
    re = err;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic t_reset();
    bus(1'b0, 12'h000, 32'h0);
    chk("ctrl", rd, 32'h0);
    bus(1'b0, 12'h010, 32'h0);
    chk("duty", rd, 32'h0);
    bus(1'b0, 12'h030, 32'h0);
    chk("err", re, 32'h1);
    chk("q1", q1, 32'h0);
  endtask
  task automatic t_soft();
    wr(12'h000, 32'h30);
    w8(4);
    chk("q1", q1, 32'h1);
    chk("q2", q2, 32'h1);
    wr(12'h000, 32'h10);
    w8(4);
    chk("q2", q2, 32'h0);
  endtask
  task automatic t_pwm();
    wr(12'h000, 32'h35);
    wr(12'h010, 32'h3E80);
    w8(300);
    chk("q1", q1, 32'h0);
    wr(12'h014, 32'hF4240);
    wr(12'h020, 32'h1F40);
    wr(12'h024, 32'h7A120);
    w8(1100);
    chk("h1", h1, 32'd125);
    chk("p1", p1, 32'd250);
    chk("h2", h2, 32'd125);
    chk("p2", p2, 32'd500);
  endtask
  task automatic t_live();
    wr(12'h014, 32'h7A120);
    w8(1100);
    chk("p1", p1, 32'd500);
    chk("h1", h1, 32'd250);
    wr(12'h010, 32'h7D00);
    w8(600);
    chk("q1", q1, 32'h1);
    w8(137);
    chk("q1", q1, 32'h1);
    wr(12'h010, 32'h0);
    w8(600);
    chk("q1", q1, 32'h0);
    wr(12'h010, 32'h3E80);
    w8(300);
  endtask
  task automatic t_stop();
    wr(12'h000, 32'hF5);
    // Let the last pre-stop level reach the pin before taking it
    w8(3);
    v = q1;
    repeat (3) begin
      w8(97);
      chk("hold", q1, v);
    end
    chk("q2", q2, 32'h0);
    wr(12'h02C, 32'hF4240);
    w8(300);
    chk("q2", q2, 32'h0);
    wr(12'h028, 32'h3E80);
    w8(1100);
    chk("p2", p2, 32'd250);
    wr(12'h000, 32'h35);
    w8(1100);
    chk("p2", p2, 32'd500);
  endtask
  task automatic t_match();
    cm <= 2'h2;
    wr(12'h000, 32'h0A);
    w8(4);
    chk("q1", q1, 32'h0);
    chk("q2", q2, 32'h1);
    cm <= 2'h1;
    w8(4);
    chk("q1", q1, 32'h1);
    wr(12'h000, 32'h3F);
    w8(4);
    chk("q1", q1, 32'h0);
    chk("q2", q2, 32'h0);
  endtask
  task automatic t_reload();
    wr(12'h000, 32'h235);
    w8(10);
    chk("q1", q1, 32'h0);
    chk("q2", q2, 32'h0);
    bus(1'b0, 12'h004, 32'h0);
    chk("status", rd, 32'h0);
    bus(1'b0, 12'h000, 32'h0);
    chk("ctrl", rd, 32'h35);
    wr(12'h014, 32'hF4240);
    w8(300);
    chk("q1", q1, 32'h0);
    wr(12'h010, 32'h3E80);
    w8(20);
    bus(1'b0, 12'h004, 32'h0);
    chk("status", rd, 32'h5);
  endtask
  task automatic final_report();
    $display("checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    w8(3);
    rst <= 1'b0;
    t_reset();
    t_soft();
    t_pwm();
    t_live();
    t_stop();
    t_match();
    t_reload();
    final_report();
  end
  initial begin
    w8(20000);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
